//--- common/stwfs_pkg.sv
// shared constants and types for the two-wire nonvolatile ram slave
package stwfs_pkg;

   // array geometry
   localparam int DATA_W = 8;
   localparam int ROW_W = 8;
   localparam int SEG_W = 3;
   localparam int ADDR_W = ROW_W + SEG_W;
   localparam int MEM_DEPTH = 2048;

   // slave address byte layout
   localparam int DEVTYPE_HI = 7;
   localparam int DEVTYPE_LO = 4;
   localparam int SEG_HI = 3;
   localparam int SEG_LO = 1;
   localparam int RW_BIT = 0;

   // counts and reset values
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] BITCNT_RST = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;
   localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
   localparam int SYNC_STAGES = 2;

   // fastest serial clock the sampler must resolve
   localparam int SCL_MAX_KHZ = 1000;
   localparam int MCLK_KHZ = 200000;
   localparam int SAMPLES_PER_SCL = MCLK_KHZ / SCL_MAX_KHZ;

   // bus sequencer states
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_DEVADDR,
      ST_ACKDEV,
      ST_WORDADDR,
      ST_ACKWORD,
      ST_WRDATA,
      ST_ACKWR,
      ST_RDDATA,
      ST_RDACK
   } stwfs_state_t;

   // pin samples travelling together through the synchroniser
   typedef struct packed {
      logic scl;
      logic sda;
      logic wp;
   } stwfs_pins_t;

   // array write request
   typedef struct packed {
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } stwfs_memreq_t;

endpackage

//--- rtl/stwfs_sync.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/10ps
`default_nettype none
module stwfs_sync import stwfs_pkg::*; #(
   parameter int W = 3
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // asynchronous and synchronised levels
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   // first stage feeds only the second stage
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= '1; // idle bus level, no false edge after reset
         sync_reg <= '1;
      end else begin
         meta_reg <= din;
         sync_reg <= meta_reg;
      end
   end

   assign dout = sync_reg;

endmodule // stwfs_sync
`default_nettype wire

//--- rtl/stwfs_mem.sv
// 2048 x 8 storage array with registered read data
`timescale 1ns/10ps
`default_nettype none
module stwfs_mem import stwfs_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // write port
   input wire stwfs_memreq_t req,
   // read port
   input wire logic [ADDR_W-1:0] rdAddr,
   output logic [DATA_W-1:0] rdData
);

   logic [DATA_W-1:0] array [MEM_DEPTH];

   // write one byte per request
   always_ff @(posedge mclk) begin
      if (req.we) begin
         array[req.addr] <= req.wdata;
      end
   end

   // read data comes out of a register
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdData <= BYTE_RST;
      end else begin
         rdData <= array[rdAddr];
      end
   end

endmodule // stwfs_mem
`default_nettype wire

//--- rtl/stwfs_top.sv
// two-wire serial slave and array access for a 2K x 8 nonvolatile ram
`timescale 1ns/10ps
`default_nettype none
module stwfs_top import stwfs_pkg::*; #(
   // device-type code; value is arbitrary
   parameter logic [3:0] DEV_TYPE = 4'h6
) (
   // clock and power-on reset
   input wire logic mclk,
   input wire logic arst_n,
   // serial clock pin
   input wire logic sclPin,
   // serial data pin, open-drain
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // write-protect pin
   input wire logic wpPin,
   // sequencer observation
   output logic busActive
);

   // true in the states where this end pulls the acknowledge
   function automatic logic isAck(input stwfs_state_t s);
      return (s == ST_ACKDEV) || (s == ST_ACKWORD) || (s == ST_ACKWR);
   endfunction

   // true in the states where a byte is shifted
   function automatic logic isByte(input stwfs_state_t s);
      return (s == ST_DEVADDR) || (s == ST_WORDADDR) || (s == ST_WRDATA) ||
             (s == ST_RDDATA);
   endfunction

   // synchronised pins and their previous samples
   stwfs_pins_t pinsRaw;
   stwfs_pins_t pins;
   logic sclPrev_reg;
   logic sdaPrev_reg;

   // clock edges and bus conditions
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;
   logic busCond;

   // sequencer and byte shifting
   stwfs_state_t state_reg;
   logic [2:0] bitCnt_reg;
   logic [DATA_W-1:0] shift_reg;
   logic [DATA_W-1:0] shift_next;
   logic byteDone;
   logic devMatch;
   logic rw_reg;

   // address latch and array access
   logic [ADDR_W-1:0] addr_reg;
   logic wrCommit;
   stwfs_memreq_t memReq_reg;
   logic [DATA_W-1:0] memRdata;

   // outgoing bit and pin drive
   logic [2:0] bitIdx;
   logic rdBit;
   logic sdaOut_reg;
   logic sdaOe_reg;
   logic busActive_reg;

   // pins enter through the synchroniser; the wp pull-down lives in the pad
   assign pinsRaw.scl = sclPin;
   assign pinsRaw.sda = sdaIn;
   assign pinsRaw.wp = wpPin;

   // 200 MHz sampling resolves edges well beyond a 1 MHz serial clock
   stwfs_sync #(
      .W(3)
   ) stwfs_sync_inst (
      .mclk(mclk),
      .arst_n(arst_n),
      .din(pinsRaw),
      .dout(pins)
   );

   // previous samples for edge detection
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sclPrev_reg <= 1'b1;
         sdaPrev_reg <= 1'b1;
      end else begin
         sclPrev_reg <= pins.scl;
         sdaPrev_reg <= pins.sda;
      end
   end

   // clock edges and bus conditions
   assign sclRise = pins.scl && !sclPrev_reg;
   assign sclFall = !pins.scl && sclPrev_reg;
   assign startSeen = pins.scl && sclPrev_reg && sdaPrev_reg && !pins.sda;
   assign stopSeen = pins.scl && sclPrev_reg && !sdaPrev_reg && pins.sda;

   // either condition aborts the byte in flight
   assign busCond = startSeen || stopSeen;

   // incoming byte, msb first
   assign shift_next = {shift_reg[DATA_W-2:0], pins.sda};
   assign byteDone = sclRise && (bitCnt_reg == LAST_BIT);
   assign devMatch = (shift_next[DEVTYPE_HI:DEVTYPE_LO] == DEV_TYPE);

   // bus sequencer; start or stop aborts anything in flight
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_IDLE;
      end else if (startSeen) begin
         state_reg <= ST_DEVADDR;
      end else if (stopSeen) begin
         state_reg <= ST_IDLE;
      end else if (sclRise) begin
         case (state_reg)
            ST_DEVADDR: begin
               if (byteDone) begin
                  state_reg <= devMatch ? ST_ACKDEV : ST_IDLE;
               end
            end
            ST_ACKDEV: begin
               state_reg <= rw_reg ? ST_RDDATA : ST_WORDADDR;
            end
            ST_WORDADDR: begin
               if (byteDone) begin
                  state_reg <= ST_ACKWORD;
               end
            end
            ST_ACKWORD, ST_ACKWR: begin
               state_reg <= ST_WRDATA;
            end
            ST_WRDATA: begin
               if (byteDone) begin
                  state_reg <= ST_ACKWR;
               end
            end
            ST_RDDATA: begin
               if (byteDone) begin
                  state_reg <= ST_RDACK;
               end
            end
            ST_RDACK: begin
               // master ack low keeps reading, release ends the read
               state_reg <= pins.sda ? ST_IDLE : ST_RDDATA;
            end
            default: begin
               state_reg <= state_reg;
            end
         endcase
      end
   end

   // bit counter within a byte
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         bitCnt_reg <= BITCNT_RST;
      end else if (busCond) begin
         bitCnt_reg <= BITCNT_RST;
      end else if (sclRise) begin
         if (isByte(state_reg)) begin
            bitCnt_reg <= bitCnt_reg + 3'h1; // wraps to zero after bit 7
         end else begin
            bitCnt_reg <= BITCNT_RST;
         end
      end
   end

   // receive shifter, sampled on the rising clock edge
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         shift_reg <= BYTE_RST;
      end else if (sclRise && isByte(state_reg)) begin
         shift_reg <= shift_next;
      end
   end

   // direction bit of the slave address
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rw_reg <= 1'b0;
      end else if (byteDone && (state_reg == ST_DEVADDR) && devMatch) begin
         rw_reg <= shift_next[RW_BIT];
      end
   end

   // address latch: segment from slave byte, row from word byte
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         addr_reg <= ADDR_RST;
      end else if (byteDone && !busCond) begin
         case (state_reg)
            ST_DEVADDR: begin
               if (devMatch) begin
                  // keep the row, take the segment
                  addr_reg <= {shift_next[SEG_HI:SEG_LO], addr_reg[ROW_W-1:0]};
               end
            end
            ST_WORDADDR: begin
               addr_reg <= {addr_reg[ADDR_W-1:ROW_W], shift_next};
            end
            ST_WRDATA, ST_RDDATA: begin
               // natural 11-bit wrap from 7FFh to 000h
               addr_reg <= addr_reg + ADDR_ONE;
            end
            default: begin
               addr_reg <= addr_reg;
            end
         endcase
      end
   end

   // a data byte is complete at its eighth rising edge
   assign wrCommit = byteDone && (state_reg == ST_WRDATA);

   // array write issued at the eighth rising edge only
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         memReq_reg <= '0;
      end else if (wrCommit) begin
         memReq_reg.we <= !pins.wp;
         memReq_reg.addr <= addr_reg;
         memReq_reg.wdata <= shift_next;
      end else begin
         memReq_reg.we <= 1'b0;
      end
   end

   // storage array; read address follows the latch
   stwfs_mem stwfs_mem_inst (
      .mclk(mclk),
      .arst_n(arst_n),
      .req(memReq_reg),
      .rdAddr(addr_reg),
      .rdData(memRdata)
   );

   // bit of the outgoing byte, msb first
   assign bitIdx = LAST_BIT - bitCnt_reg;
   assign rdBit = memRdata[bitIdx];

   // data line drive changes on the falling clock edge; a start or stop releases it at once
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sdaOe_reg <= 1'b0;
      end else if (busCond) begin
         sdaOe_reg <= 1'b0;
      end else if (sclFall) begin
         if (isAck(state_reg)) begin
            sdaOe_reg <= 1'b1;
         end else if (state_reg == ST_RDDATA) begin
            // pull low for a zero, release for a one
            sdaOe_reg <= !rdBit;
         end else begin
            sdaOe_reg <= 1'b0;
         end
      end
   end

   // open-drain level is always low; only the enable moves
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sdaOut_reg <= 1'b0;
      end else begin
         sdaOut_reg <= 1'b0;
      end
   end

   // flag for any transaction in progress
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         busActive_reg <= 1'b0;
      end else begin
         busActive_reg <= (state_reg != ST_IDLE);
      end
   end

   // outputs straight from flops
   assign sdaOut = sdaOut_reg;
   assign sdaOe = sdaOe_reg;
   assign busActive = busActive_reg;

endmodule // stwfs_top
`default_nettype wire

//--- test/stwfs_props.sv
// pin-level assertions for the two-wire ram slave
`timescale 1ns/10ps
`default_nettype none
module stwfs_props import stwfs_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // serial pins and write protect
   input wire logic sclPin,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic wpPin,
   // observation
   input wire logic busActive
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   // bus conditions and device drive steps
   sequence s_start;
      sclPin && $past(sclPin) && $fell(sdaIn);
   endsequence
   sequence s_stop;
      sclPin && $past(sclPin) && $rose(sdaIn);
   endsequence
   sequence s_drive;
      $rose(sdaOe);
   endsequence
   sequence s_release;
      $fell(sdaOe);
   endsequence
   property p_odrain;
      sdaOut == 1'b0;
   endproperty
   property p_riseLow;
      s_drive |-> !sclPin && !$past(sclPin, 3);
   endproperty
   property p_holdHigh;
      sclPin [*5] |-> $stable(sdaOe);
   endproperty
   property p_stable4;
      s_drive |=> sdaOe [*4];
   endproperty
   property p_startBusy;
      s_start |-> ##[2:8] busActive;
   endproperty
   property p_stopIdle;
      s_stop |-> ##[2:8] !busActive;
   endproperty
   property p_rstQuiet;
      $rose(arst_n) |-> (!sdaOe && !busActive) [*3];
   endproperty
   property p_oeActive;
      sdaOe |-> busActive;
   endproperty
   property p_fallLow;
      s_release |-> !sclPin;
   endproperty
   a_odrain: assert property (p_odrain) else $error("data pin driven high");
   a_riseLow: assert property (p_riseLow) else $error("drive not after clock fall");
   a_holdHigh: assert property (p_holdHigh) else $error("drive changed in clock high");
   a_stable4: assert property (p_stable4) else $error("drive pulse too short");
   a_startBusy: assert property (p_startBusy) else $error("start not accepted");
   a_stopIdle: assert property (p_stopIdle) else $error("stop did not idle");
   a_rstQuiet: assert property (p_rstQuiet) else $error("active after reset");
   a_oeActive: assert property (p_oeActive) else $error("drive while idle");
   a_fallLow: assert property (p_fallLow) else $error("release not in clock low");
endmodule // stwfs_props
`default_nettype wire

//--- test/stwfs_master.sv
// behavioural two-wire bus master facing the ram slave
`timescale 1ns/10ps
`default_nettype none
module stwfs_master import stwfs_pkg::*; (
   // clock
   input wire logic mclk,
   // sensed data wire
   input wire logic sdaLine,
   // driven clock and data, data high means released
   output logic sclPin,
   output logic sdaDrv
);
   // idle bus, both lines high
   initial begin
      sclPin = 1'b1;
      sdaDrv = 1'b1;
   end
   // wait whole cycles, then move just after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // start or repeated start: data falls while clock high
   task automatic start();
      sdaDrv = 1'b1;
      tick(4);
      sclPin = 1'b1;
      tick(8);
      sdaDrv = 1'b0;
      tick(8);
      sclPin = 1'b0;
      tick(2);
   endtask
   // stop: data rises while clock high, clock stands high after
   task automatic stop();
      sdaDrv = 1'b0;
      tick(6);
      sclPin = 1'b1;
      tick(8);
      sdaDrv = 1'b1;
      tick(8);
   endtask
   // one bit, data set while clock low, sampled mid-high, 80 ns period
   task automatic bitIo(input logic b, output logic r);
      sdaDrv = b;
      tick(6);
      sclPin = 1'b1;
      tick(4);
      r = sdaLine;
      tick(4);
      sclPin = 1'b0;
      tick(2);
   endtask
   // eight bits msb first, then the acknowledge slot
   task automatic byteIo(input logic [7:0] d, input logic a, output logic [7:0] q,
                         output logic ak);
      for (int i = 7; i >= 0; i--) begin
         bitIo(d[i], q[i]);
      end
      bitIo(a, ak);
   endtask
endmodule // stwfs_master
`default_nettype wire

//--- test/test_stwfs_top.sv
// self-checking bench for the two-wire ram slave
`timescale 1ns/10ps
`default_nettype none
module test_stwfs_top import stwfs_pkg::*;;
   localparam logic [3:0] DT = 4'h6; // device-type code, arbitrary
   logic mclk;
   logic arst_n;
   logic sclPin;
   logic sdaDrv;
   logic wpConn;
   logic wpVal;
   logic sdaOut;
   logic sdaOe;
   logic busActive;
   logic b;
   logic [7:0] rv;
   logic [10:0] ra;
   wire logic sdaLine;
   wire logic wpPin;
   int error_cnt;
   int n_tests;
   int seed;
   logic [7:0] expQ[$];
   logic [7:0] obsQ[$];
   string nameQ[$];
   // pull-up on data, pull-down on write protect
   assign sdaLine = sdaDrv & ~sdaOe;
   assign wpPin = wpConn ? wpVal : 1'b0;
   stwfs_top #(.DEV_TYPE(DT)) stwfs_top_inst (.mclk(mclk), .arst_n(arst_n), .sclPin(sclPin),
      .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .wpPin(wpPin), .busActive(busActive));
   stwfs_master stwfs_master_inst (.mclk(mclk), .sdaLine(sdaLine), .sclPin(sclPin),
      .sdaDrv(sdaDrv));
   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // compare one result
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // watcher: oldest note against each result
   initial begin
      forever begin
         wait (obsQ.size() > 0);
         chk(nameQ.pop_front(), obsQ.pop_front(), expQ.pop_front());
      end
   end
   // note an expectation with its result
   task automatic note(input string n, input logic [7:0] e, input logic [7:0] s);
      nameQ.push_back(n);
      expQ.push_back(e);
      obsQ.push_back(s);
   endtask
   // byte to the slave, acknowledge noted
   task automatic wrB(input logic [7:0] d, input logic expAck);
      logic [7:0] q;
      logic ak;
      stwfs_master_inst.byteIo(d, 1'b1, q, ak);
      note("ackBit", {7'h00, expAck}, {7'h00, ak});
   endtask
   // byte from the slave, data noted
   task automatic rdB(input logic ackOut, input logic [7:0] expD);
      logic [7:0] q;
      logic ak;
      stwfs_master_inst.byteIo(8'hff, ackOut, q, ak);
      note("rxByte", expD, q);
   endtask
   // write header setting the pointer
   task automatic setPtr(input logic [10:0] a);
      stwfs_master_inst.start();
      note("busActive", 8'h01, {7'h00, busActive});
      wrB({DT, a[10:8], 1'b0}, 1'b0);
      wrB(a[7:0], 1'b0);
   endtask
   // pointer then repeated start into read
   task automatic rdAt(input logic [10:0] a);
      setPtr(a);
      stwfs_master_inst.start();
      wrB({DT, a[10:8], 1'b1}, 1'b0);
   endtask
   // counts and verdict
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (100000) @(posedge mclk);
      error_cnt++;
      final_report();
   end
   // main sequence
   initial begin
      seed = 18143;
      error_cnt = 0;
      n_tests = 0;
      arst_n = 1'b0;
      wpConn = 1'b0;
      wpVal = 1'b0;
      repeat (10) @(posedge mclk);
      #1 arst_n = 1'b1;
      repeat (8) @(posedge mclk);
      // burst write over the top of the array
      rv = 8'($random(seed));
      setPtr(11'h7fe);
      wrB(8'ha5, 1'b0);
      wrB(8'h3c, 1'b0);
      wrB(rv, 1'b0);
      // read at once, wrapping to zero
      rdAt(11'h7fe);
      rdB(1'b0, 8'ha5);
      rdB(1'b0, 8'h3c);
      rdB(1'b1, rv);
      stwfs_master_inst.stop();
      note("idlePins", 8'h00, {6'h00, sdaOut, busActive});
      // pointer set in segment 0, read from segment 7
      setPtr(11'h0fe);
      stwfs_master_inst.stop();
      stwfs_master_inst.start();
      wrB({DT, 3'h7, 1'b1}, 1'b0);
      rdB(1'b1, 8'ha5);
      stwfs_master_inst.stop();
      // protected write is acked but not stored
      wpConn = 1'b1;
      wpVal = 1'b1;
      setPtr(11'h7fe);
      wrB(8'h11, 1'b0);
      stwfs_master_inst.stop();
      wpConn = 1'b0;
      rdAt(11'h7fe);
      rdB(1'b1, 8'ha5);
      stwfs_master_inst.stop();
      // stop after four data bits leaves the byte
      setPtr(11'h7fe);
      for (int i = 0; i < 4; i++) begin
         stwfs_master_inst.bitIo(1'b0, b);
      end
      stwfs_master_inst.stop();
      rdAt(11'h7fe);
      rdB(1'b1, 8'ha5);
      stwfs_master_inst.stop();
      // every foreign device type is refused
      for (int t = 0; t < 16; t++) begin
         if (t != DT) begin
            stwfs_master_inst.start();
            wrB({4'(t), 3'h0, 1'b0}, 1'b1);
            note("busActive", 8'h00, {7'h00, busActive});
            stwfs_master_inst.stop();
         end
      end
      // random bytes at random places
      for (int i = 0; i < 4; i++) begin
         ra = 11'($random(seed));
         rv = 8'($random(seed));
         setPtr(ra);
         wrB(rv, 1'b0);
         stwfs_master_inst.stop();
         rdAt(ra);
         rdB(1'b1, rv);
         stwfs_master_inst.stop();
      end
      repeat (4) @(posedge mclk);
      final_report();
   end
endmodule // test_stwfs_top
bind stwfs_top stwfs_props stwfs_props_inst (.mclk(mclk), .arst_n(arst_n), .sclPin(sclPin),
   .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .wpPin(wpPin), .busActive(busActive));
`default_nettype wire
